/* ntxfr_pkg.sv */
`default_nettype none
package ntxfr_pkg;
    // instruction word width and opcodes of the transfer group
    localparam int INSN_W = 10;
    localparam logic [9:0] OP_TIMER2_LOAD = 10'h231;
    localparam logic [9:0] OP_COPY_AUX = 10'h01e;
    localparam logic [9:0] OP_TIMER1_READ = 10'h270;
    localparam logic [9:0] OP_TIMER2_READ = 10'h271;
    localparam logic [9:0] OP_RESULT_READ = 10'h279;
    localparam logic [9:0] OP_PAIR_READ = 10'h02a;
    // field positions
    localparam int NIB_W = 4;
    localparam int HI_LSB = 4;
    localparam int LO_LSB = 0;
    localparam int CONV_HI_LSB = 6;
    localparam int CONV_LO_LSB = 2;
    localparam int MODE_BIT = 3;
    localparam logic [3:0] NIB_RESET = 4'h0;

    // decoded operation
    typedef enum {
        NT_NONE, NT_T2LOAD, NT_COPYAUX, NT_T1READ, NT_T2READ,
        NT_RESREAD, NT_PAIRREAD
    } ntxfr_op_type;

    // peripheral values presented to the block
    typedef struct packed {
        logic [7:0] timer1;
        logic [7:0] timer2;
        logic [9:0] convResult;
        logic [7:0] compareReg;
        logic [7:0] pairReg;
        logic [3:0] converterControlReg;
    } ntxfr_periph_type;

    // timer-2 write strobe with its data
    typedef struct packed {
        logic strobe;
        logic [7:0] data;
    } ntxfr_t2wr_type;
endpackage : ntxfr_pkg
`default_nettype wire

/* ntxfr_nibreg.sv */
`timescale 1ns/1ps
`default_nettype none
// one 4-bit core register with load strobe; data from a flip-flop
module ntxfr_nibreg (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [3:0] din,
    output logic [3:0] q
);
    // whole state of the module
    typedef struct packed {
        logic [3:0] val;
    } ntxfr_nib_type;
    ntxfr_nib_type st_q, st_d;

    // load when asked, else hold
    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.val = din;
        end
    end

    // register the copy
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '{val: ntxfr_pkg::NIB_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.val;
endmodule : ntxfr_nibreg
`default_nettype wire

/* ntxfr_core.sv */
`timescale 1ns/1ps
`default_nettype none
module ntxfr_core (
    // clock and asynchronous reset, active low
    input wire logic mclk,
    input wire logic nrst,
    // instruction slot: valid strobe and the fetched word
    input wire logic insnValid,
    input wire logic [9:0] insnWord,
    // loads from the rest of the core; group reads override them
    input wire logic [3:0] accLoadData,
    input wire logic accLoadEn,
    input wire logic [3:0] auxLoadData,
    input wire logic auxLoadEn,
    // peripheral registers as they stand in this slot
    input wire ntxfr_pkg::ntxfr_periph_type periph,
    // write strobes toward timer 2 and its reload register
    output ntxfr_pkg::ntxfr_t2wr_type timer2Wr,
    output ntxfr_pkg::ntxfr_t2wr_type timer2ReloadWr,
    // accumulator and auxiliary register contents
    output logic [3:0] acc,
    output logic [3:0] aux,
    // status toward the sequencer
    output logic insnHit,
    output logic carryWrite,
    output logic skipNext
);
    // pairing across the whole group: the high nibble of a byte always
    // meets aux and the low nibble always meets acc, reads and writes alike

    // decode one instruction word into the transfer group
    // exact match on all ten bits: a word that differs in any bit is
    // outside the group and falls to NT_NONE, so no neighbour aliases
    function automatic ntxfr_pkg::ntxfr_op_type decode(
        input logic [9:0] w);
        case (w)
            // write toward timer 2 and its reload register
            ntxfr_pkg::OP_TIMER2_LOAD: decode = ntxfr_pkg::NT_T2LOAD;
            // register to register inside the core
            ntxfr_pkg::OP_COPY_AUX: decode = ntxfr_pkg::NT_COPYAUX;
            // byte reads split into aux and acc
            ntxfr_pkg::OP_TIMER1_READ: decode = ntxfr_pkg::NT_T1READ;
            ntxfr_pkg::OP_TIMER2_READ: decode = ntxfr_pkg::NT_T2READ;
            ntxfr_pkg::OP_RESULT_READ: decode = ntxfr_pkg::NT_RESREAD;
            ntxfr_pkg::OP_PAIR_READ: decode = ntxfr_pkg::NT_PAIRREAD;
            default: decode = ntxfr_pkg::NT_NONE;
        endcase
    endfunction : decode

    // plain part-selects, kept as functions so the field positions
    // live in one place for every split read but the converter result
    // high nibble of a byte
    function automatic logic [3:0] hiNib(input logic [7:0] b);
        hiNib = b[ntxfr_pkg::HI_LSB +: ntxfr_pkg::NIB_W];
    endfunction : hiNib

    // low nibble of a byte
    function automatic logic [3:0] loNib(input logic [7:0] b);
        loNib = b[ntxfr_pkg::LO_LSB +: ntxfr_pkg::NIB_W];
    endfunction : loNib

    // whole registered state: timer-2 write strobes and data
    // acc and aux live in their own registers below; only the strobes
    // toward the timer block are held here
    typedef struct packed {
        ntxfr_pkg::ntxfr_t2wr_type t2; // toward timer 2 itself
        ntxfr_pkg::ntxfr_t2wr_type reload; // toward its reload register
    } ntxfr_state_type;
    // st_q: strobes as driven now; st_d: what the next edge loads
    ntxfr_state_type st_q, st_d;

    // combinational helpers, rebuilt in every slot
    // op is NT_NONE in any slot without a valid group word
    ntxfr_pkg::ntxfr_op_type op; // decoded operation
    // loads into the two nibble registers, chosen below
    logic [3:0] accNext; // value loaded into accumulator
    logic [3:0] auxNext; // value loaded into aux register
    logic accLd; // accumulator load strobe
    logic auxLd; // aux load strobe
    logic compareMode; // converter in comparator mode

    // decode is purely combinational so every op retires in one cycle
    // the valid strobe gates the decode so an idle slot matches nothing
    // the mode bit is taken in the same slot as the word; no copy of it
    // is held here, so the converter's current setting always decides
    always_comb begin
        op = insnValid ? decode(insnWord) : ntxfr_pkg::NT_NONE;
        compareMode = periph.converterControlReg[
            ntxfr_pkg::MODE_BIT];
    end

    // data selection; other core ops reach the registers via load ports
    // defaults hand both registers to the outside loads; every read of the
    // group takes both load strobes, so an outside load in that slot is lost
    always_comb begin
        accNext = accLoadData;
        auxNext = auxLoadData;
        accLd = accLoadEn;
        auxLd = auxLoadEn;
        st_d = '0; // strobes low unless timer 2 is written
        case (op)
            ntxfr_pkg::NT_T2LOAD: begin
                // high nibble from aux, low from accumulator, both targets
                // acc and aux are only read here, as they stand before this
                // edge, so outside loads in the same slot still land
                // both strobes rise together: timer and reload never drift
                st_d.t2.strobe = 1'b1;
                st_d.t2.data = {aux, acc};
                st_d.reload.strobe = 1'b1;
                st_d.reload.data = {aux, acc};
            end
            ntxfr_pkg::NT_COPYAUX: begin
                // acc takes aux as it stood before the edge; the aux load
                // strobe is forced low, so an outside aux load in this slot
                // is dropped and aux keeps its value
                accNext = aux;
                accLd = 1'b1;
                auxLd = 1'b0;
            end
            ntxfr_pkg::NT_T1READ: begin
                // high nibble to aux, low nibble to acc; the timer is taken
                // as it stands in this slot, a count on the same edge is
                // seen only by the next read
                auxNext = hiNib(periph.timer1);
                accNext = loNib(periph.timer1);
                accLd = 1'b1;
                auxLd = 1'b1;
            end
            ntxfr_pkg::NT_T2READ: begin
                // same split from timer 2; the counter is read, not the
                // reload register
                auxNext = hiNib(periph.timer2);
                accNext = loNib(periph.timer2);
                accLd = 1'b1;
                auxLd = 1'b1;
            end
            ntxfr_pkg::NT_RESREAD: begin
                // one mode test decides both nibbles, so they always come
                // from the same source
                if (compareMode) begin
                    // mode bit high: the eight-bit comparator register
                    auxNext = hiNib(periph.compareReg);
                    accNext = loNib(periph.compareReg);
                end else begin
                    // mode bit low: top eight bits of the ten-bit result
                    // bits 1..0 of the result are not reachable here
                    auxNext = periph.convResult[
                        ntxfr_pkg::CONV_HI_LSB +: ntxfr_pkg::NIB_W];
                    accNext = periph.convResult[
                        ntxfr_pkg::CONV_LO_LSB +: ntxfr_pkg::NIB_W];
                end
                accLd = 1'b1;
                auxLd = 1'b1;
            end
            ntxfr_pkg::NT_PAIRREAD: begin
                // pair register split like the timers; a write to it in
                // the same slot is not seen until the next read
                auxNext = hiNib(periph.pairReg);
                accNext = loNib(periph.pairReg);
                accLd = 1'b1;
                auxLd = 1'b1;
            end
            default: begin
                // not in this group: leave ports in charge
                // and keep both strobes low
            end
        endcase
    end

    // timer-2 write strobes registered, one cycle after the op
    // the register costs a cycle of latency but keeps the timer write
    // free of glitches from the combinational decode
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // strobes low through reset: no stray timer write leaves it
            st_q <= '0;
        end else begin
            // one-cycle pulse: the next slot rewrites st_d
            st_q <= st_d;
        end
    end

    // both core registers come out of reset at zero
    // accumulator: outside loads and group reads share one load port
    // outside logic sees the new value in the next slot
    ntxfr_nibreg u_acc (
        .mclk(mclk),
        .nrst(nrst),
        .load(accLd),
        .din(accNext),
        .q(acc)
    );

    // auxiliary register
    // copy-aux holds its load strobe low, every other read loads it
    ntxfr_nibreg u_aux (
        .mclk(mclk),
        .nrst(nrst),
        .load(auxLd),
        .din(auxNext),
        .q(aux)
    );

    // both strobes come straight from flip-flops
    assign timer2Wr = st_q.t2;
    assign timer2ReloadWr = st_q.reload;
    // combinational: tells the sequencer in the same slot that the word
    // belongs to this group
    assign insnHit = (op != ntxfr_pkg::NT_NONE);
    // the group never writes carry nor skips; tied low so the sequencer
    // can merge these with the flags of other groups
    assign carryWrite = 1'b0;
    assign skipNext = 1'b0;
endmodule : ntxfr_core
`default_nettype wire

/* ntxfr_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the transfer group at the core's ports
module ntxfr_core_props (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic insnValid,
    input wire logic [9:0] insnWord,
    input wire ntxfr_pkg::ntxfr_periph_type periph,
    input wire ntxfr_pkg::ntxfr_t2wr_type timer2Wr,
    input wire ntxfr_pkg::ntxfr_t2wr_type timer2ReloadWr,
    input wire logic [3:0] acc,
    input wire logic [3:0] aux,
    input wire logic carryWrite,
    input wire logic skipNext
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // opcode taken this cycle; zero when idle, since zero is no group code
    logic [9:0] w;
    assign w = insnValid ? insnWord : 10'h000;
    // mode select for the result read
    logic cmp;
    assign cmp = periph.converterControlReg[ntxfr_pkg::MODE_BIT];
    chk_t2_load: assert property (
        w == ntxfr_pkg::OP_TIMER2_LOAD |=> timer2Wr.strobe
        && timer2Wr.data == {$past(aux), $past(acc)}) else $error("t2 load");
    chk_t2_quiet: assert property (
        w != ntxfr_pkg::OP_TIMER2_LOAD |=> !timer2Wr.strobe)
        else $error("stray strobe");
    chk_reload_twin: assert property (
        timer2ReloadWr == timer2Wr) else $error("reload differs");
    chk_copy_aux: assert property (
        w == ntxfr_pkg::OP_COPY_AUX |=> acc == $past(aux) && $stable(aux))
        else $error("copy aux");
    chk_t1_read: assert property (
        w == ntxfr_pkg::OP_TIMER1_READ |=> {aux, acc} == $past(periph.timer1))
        else $error("timer1 read");
    chk_t2_read: assert property (
        w == ntxfr_pkg::OP_TIMER2_READ |=> {aux, acc} == $past(periph.timer2))
        else $error("timer2 read");
    chk_conv_read: assert property (
        w == ntxfr_pkg::OP_RESULT_READ && !cmp
        |=> {aux, acc} == $past(periph.convResult[9:2])) else $error("conv");
    chk_cmp_read: assert property (
        w == ntxfr_pkg::OP_RESULT_READ && cmp
        |=> {aux, acc} == $past(periph.compareReg)) else $error("compare");
    chk_pair_read: assert property (
        w == ntxfr_pkg::OP_PAIR_READ |=> {aux, acc} == $past(periph.pairReg))
        else $error("pair read");
    chk_no_skip: assert property (
        !carryWrite && !skipNext) else $error("carry or skip");
    cover property (w == ntxfr_pkg::OP_TIMER2_LOAD);
    cover property (w == ntxfr_pkg::OP_RESULT_READ && cmp);
    cover property (w == ntxfr_pkg::OP_RESULT_READ && !cmp);
endmodule : ntxfr_core_props
bind ntxfr_core ntxfr_core_props ntxfr_core_props_inst (.mclk, .nrst,
    .insnValid, .insnWord, .periph, .timer2Wr, .timer2ReloadWr, .acc,
    .aux, .carryWrite, .skipNext);
`default_nettype wire

/* tb_nibble_transfer_instructions.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_nibble_transfer_instructions;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic insnValid = 1'b0;
    logic [9:0] insnWord = 10'h000;
    logic [3:0] accLoadData = 4'h0;
    logic accLoadEn = 1'b0;
    logic [3:0] auxLoadData = 4'h0;
    logic auxLoadEn = 1'b0;
    ntxfr_pkg::ntxfr_periph_type periph = '0;
    ntxfr_pkg::ntxfr_t2wr_type timer2Wr, timer2ReloadWr;
    logic [3:0] acc, aux, mA = 4'h0, mB = 4'h0; // mA/mB: bench acc/aux
    logic insnHit, carryWrite, skipNext, pend = 1'b0;
    int err_count = 0, n_checks = 0, cycles = 0, k;
    logic [31:0] seed = 32'h0001299b;
    logic [16:0] expQ[$]; // {strobe, strobe data, aux, acc}
    logic [16:0] note;
    logic [9:0] ops[6] = '{ntxfr_pkg::OP_TIMER2_LOAD, ntxfr_pkg::OP_COPY_AUX,
        ntxfr_pkg::OP_TIMER1_READ, ntxfr_pkg::OP_TIMER2_READ,
        ntxfr_pkg::OP_RESULT_READ, ntxfr_pkg::OP_PAIR_READ};
    always #4 mclk = ~mclk;
    ntxfr_core ntxfr_core_inst (.mclk, .nrst, .insnValid, .insnWord,
        .accLoadData, .accLoadEn, .auxLoadData, .auxLoadEn, .periph,
        .timer2Wr, .timer2ReloadWr, .acc, .aux, .insnHit, .carryWrite,
        .skipNext);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    // one instruction slot; the note of the previous slot is queued at the
    // edge that makes its result visible, so the watcher never runs ahead
    task automatic step(input logic v, input logic [9:0] w);
        logic [31:0] r;
        logic grp;
        @(posedge mclk);
        if (pend) expQ.push_back(note);
        #1;
        r = xs();
        periph = 46'({xs(), xs()});
        insnValid = v;
        insnWord = w;
        grp = v && (w inside {ops});
        accLoadData = r[3:0];
        auxLoadData = r[7:4];
        // outside loads enabled at random on each slot: group reads must override them
        accLoadEn = r[8];
        auxLoadEn = r[9];
        note[16] = v && w == ntxfr_pkg::OP_TIMER2_LOAD;
        note[15:8] = note[16] ? {mB, mA} : 8'h00;
        // the timer-2 load only reads acc and aux, so outside loads land
        if (!grp || w == ntxfr_pkg::OP_TIMER2_LOAD) begin
            mA = accLoadEn ? accLoadData : mA;
            mB = auxLoadEn ? auxLoadData : mB;
        end else case (w)
            ntxfr_pkg::OP_COPY_AUX: mA = mB;
            ntxfr_pkg::OP_TIMER1_READ: {mB, mA} = periph.timer1;
            ntxfr_pkg::OP_TIMER2_READ: {mB, mA} = periph.timer2;
            ntxfr_pkg::OP_PAIR_READ: {mB, mA} = periph.pairReg;
            ntxfr_pkg::OP_RESULT_READ: {mB, mA} = periph.converterControlReg[3]
                ? periph.compareReg : periph.convResult[9:2];
            default: ;
        endcase
        note[7:0] = {mB, mA};
        pend = 1'b1;
    endtask : step
    // watcher: compares the oldest note once the outputs have settled
    always @(posedge mclk) begin
        logic [16:0] e, s, t;
        #2;
        if (expQ.size() > 0) begin
            e = expQ.pop_front();
            // strobe data only counts while its strobe stands
            s = {timer2Wr.strobe, 8'h00, aux, acc};
            t = {timer2ReloadWr.strobe, 8'h00, aux, acc};
            if (timer2Wr.strobe) s[15:8] = timer2Wr.data;
            if (timer2ReloadWr.strobe) t[15:8] = timer2ReloadWr.data;
            check(s[16:8], e[16:8]);
            check(t[16:8], e[16:8]);
            check(s[7:4], e[7:4]);
            check(s[3:0], e[3:0]);
            check({carryWrite, skipNext}, 2'b00);
            check(insnHit, insnValid && (insnWord inside {ops}));
        end
    end
    // hang guard, well past the 600 or so slots the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        #1 nrst = 1'b1;
        // random group slots, back to back, idle words and invalid slots
        repeat (600) begin
            k = xs() % 7;
            step(xs() % 5 != 0, k == 6 ? 10'h000 : ops[k]);
        end
        step(1'b0, 10'h000);
        repeat (2) @(posedge mclk);
        test_done();
    end
endmodule : tb_nibble_transfer_instructions
`default_nettype wire
